/* File: irqw_core_model.sv */
// processor core model: takes interrupt calls, keeps a stack and issues returns
`timescale 1ns/1ps

module irqw_core_model #(
   parameter int PC_W = 13,
   parameter int DEPTH = 2
) (
   input wire logic clock_i,
   input wire logic irq_req_i,
   input wire logic push_pc_i,
   input wire logic ack_en_i,
   input wire logic fill_i,
   input wire logic [1:0] ret_cmd_i,
   output logic irq_ack_o,
   output logic [PC_W-1:0] pc_o,
   output logic [PC_W-1:0] taken_pc_o,
   output logic return_from_interrupt_instr_o,
   output logic ret_o,
   output logic stack_full_o
);
   int depth;

   // ----------------------------------------------------------------
   // start-up state, no call pending
   // ----------------------------------------------------------------
   initial begin
      depth = 0;
      irq_ack_o = 1'b0;
      pc_o = PC_W'(16'h0100);
      taken_pc_o = '0;
   end

   // ----------------------------------------------------------------
   // fetch, call take and stack bookkeeping
   // ----------------------------------------------------------------
   // ack is a single-cycle pulse so one request is never taken twice
   always @(posedge clock_i) begin
      irq_ack_o <= ack_en_i && irq_req_i && !irq_ack_o;
      if (irq_ack_o && irq_req_i) begin
         taken_pc_o <= pc_o;
      end
      pc_o <= pc_o + 1'b1;
      // the service routine makes no calls of its own, so one push per entry
      depth <= depth + int'(push_pc_i) - int'(return_from_interrupt_instr_o || ret_o);
   end

   // returns follow the bench command; fill stands for a stack used up by calls
   assign return_from_interrupt_instr_o = (ret_cmd_i == 2'h1);
   assign ret_o = (ret_cmd_i == 2'h2);
   assign stack_full_o = fill_i || (depth >= DEPTH);
endmodule

/* File: irqw_ctrl.sv */
// interrupt request gating, vectoring, service clearing and wake-up
`timescale 1ns/1ps
`include "irqw_defines.svh"

module irqw_ctrl #(
   parameter int PC_W = 13,
   parameter int NUM_MF = 4
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   // peripheral sources
   input wire logic low_voltage_i,
   input wire irqw_pkg::irqw_ser_cond_t serial_cond_i,
   input wire logic nvm_done_i,
   input wire logic time_base_ovf_i,
   input wire logic [NUM_MF-1:0] mf_flags_i,
   input wire logic [NUM_MF-1:0] mf_enable_i,
   // software control of flags and enables
   input wire irqw_pkg::irqw_src_t src_enable_i,
   input wire irqw_pkg::irqw_src_t flag_set_i,
   input wire irqw_pkg::irqw_src_t flag_clr_i,
   input wire logic gie_set_i,
   input wire logic gie_clr_i,
   // processor core
   input wire logic stack_full_i,
   input wire logic irq_ack_i,
   input wire logic [PC_W-1:0] pc_i,
   input wire logic return_from_interrupt_instr_i,
   input wire logic plain_return_instr_i,
   input wire logic sleep_mode_i,
   output logic irq_req_o,
   output logic [PC_W-1:0] vector_o,
   output logic push_pc_o,
   output logic [PC_W-1:0] push_data_o,
   output logic wake_o,
   output logic serial_irq_n_o,
   output irqw_pkg::irqw_src_t flags_o,
   output logic global_irq_enable_o,
   output logic in_service_o
);
   import irqw_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // refused at elaboration, so a bad width never reaches simulation
   if (PC_W < 13 || PC_W > 24) begin : g_pc_w_chk
      $error("PC_W must lie between 13 and 24");
   end
   if (NUM_MF < 1 || NUM_MF > 16) begin : g_num_mf_chk
      $error("NUM_MF must lie between 1 and 16");
   end

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // keep only the lowest set bit, the highest priority request
   function automatic logic [`IRQW_NUM_SRC-1:0] first_one(input logic [`IRQW_NUM_SRC-1:0] v);
      logic [`IRQW_NUM_SRC-1:0] r;
      r = '0;
      for (int i = `IRQW_NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = '0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction

   // vector address of a one-hot source selection
   function automatic logic [PC_W-1:0] vec_of(input logic [`IRQW_NUM_SRC-1:0] sel);
      logic [12:0] v;
      v = 13'h0000;
      if (sel[`IRQW_IDX_LOWV]) v = `IRQW_VEC_LOWV;
      if (sel[`IRQW_IDX_SERIAL]) v = `IRQW_VEC_SERIAL;
      if (sel[`IRQW_IDX_NVM]) v = `IRQW_VEC_NVM;
      if (sel[`IRQW_IDX_TB]) v = `IRQW_VEC_TB;
      if (sel[`IRQW_IDX_GRP]) v = `IRQW_VEC_GRP;
      return PC_W'(v);
   endfunction

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_q;
   logic rst_n;

   // asynchronous assert, release after two edges
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // ----------------------------------------------------------------
   // serial-port attention pulse
   // ----------------------------------------------------------------
   logic [5:0] ser_cond_q;
   wire [5:0] ser_cond_now = serial_cond_i;
   wire ser_any_now = |ser_cond_now;
   wire ser_any_prev = |ser_cond_q;
   logic ser_pulse_n_q;

   // the first condition to rise while none stands gives one low cycle; a condition held high does not
   // keep re-raising the request after it has been serviced
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         ser_cond_q <= `IRQW_SER_COND_RST;
         ser_pulse_n_q <= 1'b1;
      end else begin
         ser_cond_q <= ser_cond_now;
         ser_pulse_n_q <= ~(ser_any_now & ~ser_any_prev);
      end
   end
   assign serial_irq_n_o = ser_pulse_n_q;

   // ----------------------------------------------------------------
   // multi-function group request
   // ----------------------------------------------------------------
   logic mf_any_q;
   wire mf_any_now = |(mf_flags_i & mf_enable_i);
   wire mf_rise = mf_any_now & ~mf_any_q;

   // members keep their own flags; only the group flag is ours
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         mf_any_q <= 1'b0;
      end else begin
         mf_any_q <= mf_any_now;
      end
   end

   // ----------------------------------------------------------------
   // request flags
   // ----------------------------------------------------------------
   logic [`IRQW_NUM_SRC-1:0] flags_q;
   logic [`IRQW_NUM_SRC-1:0] flags_d;
   logic [`IRQW_NUM_SRC-1:0] hw_set;
   logic [`IRQW_NUM_SRC-1:0] hw_clr;
   logic [`IRQW_NUM_SRC-1:0] sw_set;
   logic [`IRQW_NUM_SRC-1:0] sw_clr;
   logic [`IRQW_NUM_SRC-1:0] enables;
   logic [`IRQW_NUM_SRC-1:0] eligible;
   logic [`IRQW_NUM_SRC-1:0] sel;
   logic gie_q;
   logic take;

   assign sw_set = flag_set_i;
   assign sw_clr = flag_clr_i;
   assign enables = src_enable_i;

   // hardware set sources
   assign hw_set[`IRQW_IDX_LOWV] = low_voltage_i;
   assign hw_set[`IRQW_IDX_SERIAL] = ~ser_pulse_n_q;
   assign hw_set[`IRQW_IDX_NVM] = nvm_done_i;
   assign hw_set[`IRQW_IDX_TB] = time_base_ovf_i;
   assign hw_set[`IRQW_IDX_GRP] = mf_rise;

   // servicing clears exactly the chosen flag; the serial conditions and
   // group member flags are never touched here
   assign hw_clr = take ? sel : '0;

   // set wins over clear, so an event landing on a clear is kept;
   // nothing else clears a flag, disabled or not
   assign flags_d = (flags_q & ~(hw_clr | sw_clr)) | hw_set | sw_set;

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= `IRQW_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end
   assign flags_o = flags_q;

   // ----------------------------------------------------------------
   // gating and selection
   // ----------------------------------------------------------------
   // the stack must have room for the pushed program counter
   assign eligible = flags_q & enables & {`IRQW_NUM_SRC{gie_q & ~stack_full_i}};
   assign sel = first_one(eligible);
   assign irq_req_o = |eligible;
   assign take = irq_ack_i & irq_req_o;

   // ----------------------------------------------------------------
   // global enable and service state
   // ----------------------------------------------------------------
   irqw_state_t state_q;
   irqw_state_t state_d;
   logic gie_d;

   // entry clears the global enable; only the interrupt return or a software set sets it
   // again, a plain return leaves it low
   always_comb begin
      gie_d = gie_q;
      if (take) begin
         gie_d = 1'b0;
      end else if (return_from_interrupt_instr_i || gie_set_i) begin
         gie_d = 1'b1;
      end else if (gie_clr_i) begin
         gie_d = 1'b0;
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         IRQW_RUN: begin
            if (take) begin
               state_d = IRQW_IN_SERVICE;
            end
         end
         IRQW_IN_SERVICE: begin
            // either return ends the routine; plain return keeps enable low
            if (return_from_interrupt_instr_i || plain_return_instr_i) begin
               state_d = IRQW_RUN;
            end
         end
         default: begin
            state_d = IRQW_RUN;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         gie_q <= `IRQW_GIE_RST;
         state_q <= IRQW_RUN;
      end else begin
         gie_q <= gie_d;
         state_q <= state_d;
      end
   end
   assign global_irq_enable_o = gie_q;
   assign in_service_o = (state_q == IRQW_IN_SERVICE);

   // ----------------------------------------------------------------
   // call: vector and program counter push
   // ----------------------------------------------------------------
   logic [PC_W-1:0] vector_q;
   logic push_q;
   logic [PC_W-1:0] push_data_q;

   // only the program counter goes to the stack; accumulator and status
   // are left to the service routine
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         vector_q <= '0;
         push_q <= 1'b0;
         push_data_q <= '0;
      end else begin
         push_q <= take;
         if (take) begin
            vector_q <= vec_of(sel);
            push_data_q <= pc_i;
         end
      end
   end
   assign vector_o = vector_q;
   assign push_pc_o = push_q;
   assign push_data_o = push_data_q;

   // ----------------------------------------------------------------
   // wake-up
   // ----------------------------------------------------------------
   logic wake_q;
   wire [`IRQW_NUM_SRC-1:0] flag_rise = flags_d & ~flags_q;

   // enables play no part; only a rising flag wakes, so a flag preset high cannot wake the part
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= sleep_mode_i & (|flag_rise);
      end
   end
   assign wake_o = wake_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence lowv_seen_s;
      low_voltage_i;
   endsequence

   sequence taken_s;
      irq_ack_i && irq_req_o;
   endsequence

   lowv_sets_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      lowv_seen_s |=> flags_q[`IRQW_IDX_LOWV])
      else $error("low-voltage report did not set its flag");

   gating_ok_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      irq_req_o |-> gie_q && !stack_full_i && |(flags_q & enables))
      else $error("request raised without enables or stack room");

   service_clr_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      taken_s |=> !gie_q && push_pc_o && vector_o == vec_of($past(sel)))
      else $error("service did not clear enable or vector wrongly");

   ser_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      (ser_any_now && !ser_any_prev) |=> !serial_irq_n_o ##1 serial_irq_n_o)
      else $error("serial attention pulse not one low cycle");

   nvm_sets_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      nvm_done_i |=> flags_q[`IRQW_IDX_NVM])
      else $error("nvm cycle end did not set its flag");

   tb_sets_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      time_base_ovf_i |=> flags_q[`IRQW_IDX_TB])
      else $error("time base overflow did not set its flag");

   serial_clr_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      (take && sel[`IRQW_IDX_SERIAL] && ser_pulse_n_q && !flag_set_i.serial)
      |=> !flags_q[`IRQW_IDX_SERIAL] && !gie_q)
      else $error("serial service did not clear its flag or enable");

   nvm_clr_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      (take && sel[`IRQW_IDX_NVM] && !nvm_done_i && !flag_set_i.nvm)
      |=> !flags_q[`IRQW_IDX_NVM] && !gie_q)
      else $error("nvm service did not clear its flag or enable");

   flag_holds_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      (flags_q[`IRQW_IDX_NVM] && !(take && sel[`IRQW_IDX_NVM])
       && !flag_clr_i.nvm) |=> flags_q[`IRQW_IDX_NVM])
      else $error("nvm flag dropped without service or clear");

   wake_rise_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      (sleep_mode_i && |(flags_d & ~flags_q)) |=> wake_o)
      else $error("flag rise in sleep gave no wake-up");

   pc_push_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      taken_s |=> push_data_o == $past(pc_i) ##1 !push_pc_o)
      else $error("pushed value is not the program counter");

   return_from_interrupt_instr_sets_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      (return_from_interrupt_instr_i && !take) |=> gie_q)
      else $error("interrupt return did not set global enable");

   ret_keeps_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      (plain_return_instr_i && !gie_q && !gie_set_i && !return_from_interrupt_instr_i)
      |=> !gie_q)
      else $error("plain return changed global enable");
endmodule

/* File: irqw_defines.svh */
// constants for the interrupt request and wake-up logic
`ifndef IRQW_DEFINES_SVH
`define IRQW_DEFINES_SVH

// ----------------------------------------------------------------
// source bit positions, lowest index has highest priority
// ----------------------------------------------------------------
`define IRQW_NUM_SRC 5
`define IRQW_IDX_LOWV 0
`define IRQW_IDX_SERIAL 1
`define IRQW_IDX_NVM 2
`define IRQW_IDX_TB 3
`define IRQW_IDX_GRP 4

// ----------------------------------------------------------------
// vector addresses and reset values
// ----------------------------------------------------------------
`define IRQW_VEC_LOWV 13'h0004
`define IRQW_VEC_SERIAL 13'h0008
`define IRQW_VEC_NVM 13'h000C
`define IRQW_VEC_TB 13'h0010
`define IRQW_VEC_GRP 13'h0014
`define IRQW_FLAGS_RST 5'h00
`define IRQW_GIE_RST 1'b0
`define IRQW_SER_COND_RST 6'h00

`endif

/* File: irqw_pkg.sv */
// types shared by the interrupt request and wake-up logic
package irqw_pkg;
   // one bit per interrupt source, same order as the index constants
   typedef struct packed {
      logic grp;
      logic tb;
      logic nvm;
      logic serial;
      logic lowv;
   } irqw_src_t;

   // the six serial-port conditions that raise the serial request
   typedef struct packed {
      logic pin_wake;
      logic addr_detect;
      logic rx_overrun;
      logic rx_avail;
      logic tx_idle;
      logic tx_empty;
   } irqw_ser_cond_t;

   // service selection state
   typedef enum logic [1:0] {
      IRQW_RUN = 2'b00,
      IRQW_IN_SERVICE = 2'b01
   } irqw_state_t;
endpackage

/* File: tb.sv */
// self-checking testbench of the interrupt request and wake-up logic
`timescale 1ns/1ps
`include "irqw_defines.svh"

module tb;
   import irqw_pkg::*;

   localparam logic [12:0] VEC [5] = '{`IRQW_VEC_LOWV, `IRQW_VEC_SERIAL, `IRQW_VEC_NVM,
      `IRQW_VEC_TB, `IRQW_VEC_GRP};

   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic low_voltage_i = 1'b0;
   logic nvm_done_i = 1'b0;
   logic time_base_ovf_i = 1'b0;
   logic gie_set_i = 1'b0;
   logic gie_clr_i = 1'b0;
   logic sleep_mode_i = 1'b0;
   logic ack_en = 1'b0;
   logic fill = 1'b0;
   logic [1:0] ret_cmd = 2'h0;
   logic [3:0] mf_flags_i = 4'h0;
   logic [3:0] mf_enable_i = 4'h0;
   irqw_ser_cond_t serial_cond_i = '0;
   irqw_src_t src_enable_i = '0;
   irqw_src_t flag_set_i = '0;
   irqw_src_t flag_clr_i = '0;
   irqw_src_t flags_o;
   logic [4:0] flag_v;
   logic stack_full_i, irq_ack_i, return_from_interrupt_instr, ret, irq_req_o, push_pc_o, wake_o;
   logic serial_irq_n_o, global_irq_enable_o, in_service_o;
   logic [12:0] pc_i, vector_o, push_data_o, taken_pc;
   int errors = 0;
   int comparisons = 0;

   assign flag_v = flags_o;

   always #25 clock_i = ~clock_i;

   irqw_ctrl i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .low_voltage_i(low_voltage_i),
      .serial_cond_i(serial_cond_i), .nvm_done_i(nvm_done_i),
      .time_base_ovf_i(time_base_ovf_i), .mf_flags_i(mf_flags_i), .mf_enable_i(mf_enable_i),
      .src_enable_i(src_enable_i), .flag_set_i(flag_set_i), .flag_clr_i(flag_clr_i),
      .gie_set_i(gie_set_i), .gie_clr_i(gie_clr_i), .stack_full_i(stack_full_i),
      .irq_ack_i(irq_ack_i), .pc_i(pc_i), .return_from_interrupt_instr_i(return_from_interrupt_instr),
      .plain_return_instr_i(ret), .sleep_mode_i(sleep_mode_i), .irq_req_o(irq_req_o),
      .vector_o(vector_o), .push_pc_o(push_pc_o), .push_data_o(push_data_o),
      .wake_o(wake_o), .serial_irq_n_o(serial_irq_n_o), .flags_o(flags_o),
      .global_irq_enable_o(global_irq_enable_o), .in_service_o(in_service_o));

   irqw_core_model i_core (.clock_i(clock_i), .irq_req_i(irq_req_o), .push_pc_i(push_pc_o),
      .ack_en_i(ack_en), .fill_i(fill), .ret_cmd_i(ret_cmd), .irq_ack_o(irq_ack_i),
      .pc_o(pc_i), .taken_pc_o(taken_pc), .return_from_interrupt_instr_o(return_from_interrupt_instr), .ret_o(ret),
      .stack_full_o(stack_full_i));

   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask

   // bounded wait, a missing call shows up in the compare that follows
   task automatic wait_push();
      int n;
      n = 0;
      while (push_pc_o !== 1'b1 && n < 12) begin
         cyc(1);
         n++;
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic trigger(input int i);
      case (i)
         0: low_voltage_i = 1'b1;
         1: serial_cond_i.tx_empty = 1'b1;
         2: nvm_done_i = 1'b1;
         3: time_base_ovf_i = 1'b1;
         default: mf_flags_i[0] = 1'b1;
      endcase
      cyc(1);
      low_voltage_i = 1'b0;
      nvm_done_i = 1'b0;
      time_base_ovf_i = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // every source in turn, each return re-arms the next one
   task automatic t_service();
      src_enable_i = '1;
      mf_enable_i = 4'hF;
      ack_en = 1'b1;
      gie_set_i = 1'b1;
      cyc(1);
      gie_set_i = 1'b0;
      for (int i = 0; i < 5; i++) begin
         trigger(i);
         wait_push();
         chk("push pulse", 16'h1, push_pc_o);
         chk("vector", VEC[i], vector_o);
         chk("pushed pc", taken_pc, push_data_o);
         chk("flag after entry", 16'h0, flag_v[i]);
         chk("gie after entry", 16'h0, global_irq_enable_o);
         chk("serial line quiet", 16'h1, serial_irq_n_o);
         mf_flags_i = 4'h0;
         cyc(2);
         chk("request while serviced", 16'h0, irq_req_o);
         // serial condition still stands: service must not re-raise it
         chk("flag stays clear", 16'h0, flag_v[i]);
         serial_cond_i = '0;
         ret_cmd = 2'h1;
         cyc(1);
         ret_cmd = 2'h0;
         chk("gie after return", 16'h1, global_irq_enable_o);
         chk("in service", 16'h0, in_service_o);
      end
      ack_en = 1'b0;
   endtask

   // gating by enables and stack, pending flag kept, plain return
   task automatic t_gate();
      src_enable_i = '0;
      flag_set_i.nvm = 1'b1;
      cyc(1);
      flag_set_i.nvm = 1'b0;
      chk("disabled request", 16'h0, irq_req_o);
      cyc(3);
      chk("pending flag", 16'h1, flags_o.nvm);
      src_enable_i.nvm = 1'b1;
      cyc(1);
      chk("enabled request", 16'h1, irq_req_o);
      fill = 1'b1;
      cyc(1);
      chk("stack full request", 16'h0, irq_req_o);
      fill = 1'b0;
      gie_clr_i = 1'b1;
      cyc(1);
      gie_clr_i = 1'b0;
      chk("gie off request", 16'h0, irq_req_o);
      flag_clr_i.nvm = 1'b1;
      cyc(1);
      flag_clr_i.nvm = 1'b0;
      chk("cleared flag", 16'h0, flags_o.nvm);
      gie_set_i = 1'b1;
      cyc(1);
      gie_set_i = 1'b0;
      ack_en = 1'b1;
      trigger(2);
      wait_push();
      chk("nvm vector", VEC[2], vector_o);
      ack_en = 1'b0;
      ret_cmd = 2'h2;
      cyc(1);
      ret_cmd = 2'h0;
      chk("gie after plain return", 16'h0, global_irq_enable_o);
      chk("service ended", 16'h0, in_service_o);
   endtask

   // each of the six serial conditions, with gie off
   task automatic t_serial();
      for (int b = 0; b < 6; b++) begin
         serial_cond_i = irqw_ser_cond_t'(6'(6'h01 << b));
         cyc(1);
         chk("serial pulse low", 16'h0, serial_irq_n_o);
         cyc(1);
         chk("serial pulse end", 16'h1, serial_irq_n_o);
         chk("serial flag", 16'h1, flags_o.serial);
         serial_cond_i = '0;
         flag_clr_i.serial = 1'b1;
         cyc(1);
         flag_clr_i.serial = 1'b0;
      end
   endtask

   // wake-up with every source enable off, and a preset flag that must not wake
   task automatic t_wake();
      src_enable_i = '0;
      sleep_mode_i = 1'b1;
      low_voltage_i = 1'b1;
      cyc(1);
      chk("wake on low supply", 16'h1, wake_o);
      chk("low supply flag", 16'h1, flags_o.lowv);
      cyc(1);
      chk("wake one cycle", 16'h0, wake_o);
      low_voltage_i = 1'b0;
      trigger(2);
      chk("wake on nvm end", 16'h1, wake_o);
      chk("nvm flag", 16'h1, flags_o.nvm);
      sleep_mode_i = 1'b0;
      flag_set_i.tb = 1'b1;
      cyc(1);
      flag_set_i.tb = 1'b0;
      sleep_mode_i = 1'b1;
      trigger(3);
      chk("preset flag no wake", 16'h0, wake_o);
      cyc(1);
      chk("preset flag still no wake", 16'h0, wake_o);
      sleep_mode_i = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      cyc(12);
      resetn_i = 1'b1;
      cyc(3);
      chk("reset flags", 16'h0, flag_v);
      chk("reset gie", 16'h0, global_irq_enable_o);
      chk("reset serial line", 16'h1, serial_irq_n_o);
      t_service();
      t_gate();
      t_serial();
      t_wake();
      close_out();
   end

   // the whole run needs under a hundred cycles
   initial begin
      #(50 * 5000);
      errors++;
      close_out();
   end
endmodule
